// [hdl/ulsc_defines.svh]
`ifndef ULSC_DEFINES_SVH
`define ULSC_DEFINES_SVH
// ----------------------------------------
// register byte offsets on the apb
// ----------------------------------------
`define ULSC_OFF_DATA 8'h00
`define ULSC_OFF_IER 8'h04
`define ULSC_OFF_ISR 8'h08
`define ULSC_OFF_LCR 8'h0c
`define ULSC_OFF_MCR 8'h10
`define ULSC_OFF_LSR 8'h14
`define ULSC_OFF_MSR 8'h18
// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define ULSC_LCR_RST 8'h00
`define ULSC_MCR_RST 8'h00
`define ULSC_IER_RST 8'h00
`define ULSC_DIV_RST 16'h0000
`define ULSC_EFR_RST 8'h00
`define ULSC_MCR_MASK 8'h9f
`define ULSC_IER_MASK 8'h2f
// ----------------------------------------
// field positions
// ----------------------------------------
`define ULSC_LCR_STOP 2
`define ULSC_LCR_PEN 3
`define ULSC_LCR_EVEN 4
`define ULSC_LCR_FORCE 5
`define ULSC_LCR_BRK 6
`define ULSC_LCR_DLAB 7
`define ULSC_MCR_DTR 0
`define ULSC_MCR_RTS 1
`define ULSC_MCR_RI 2
`define ULSC_MCR_OUT 3
`define ULSC_MCR_LOOP 4
`define ULSC_MCR_PDN 7
`define ULSC_IER_RXD 0
`define ULSC_IER_THR 1
`define ULSC_IER_LINE 2
`define ULSC_IER_MDM 3
`define ULSC_IER_PDN 5
// ----------------------------------------
// interrupt source codes
// ----------------------------------------
`define ULSC_CODE_LINE 4'h6
`define ULSC_CODE_RXD 4'h4
`define ULSC_CODE_TMO 4'hc
`define ULSC_CODE_THR 4'h2
`define ULSC_CODE_MDM 4'h0
`define ULSC_CODE_NONE 4'h1
`endif

// [hdl/ulsc_pkg.sv]
package ulsc_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  // pending source, highest priority first
  typedef enum logic [2:0] {SRC_LINE, SRC_RXD, SRC_TMO, SRC_THR, SRC_MDM, SRC_NONE} ulsc_src_type;
  // character completed by the receive shifter
  typedef struct packed {
    logic done;
    logic fifo_full;
    logic par_err;
    logic frm_err;
    logic brk;
  } ulsc_rx_evt_type;
  // error flags of the character at the fifo head
  typedef struct packed {
    logic par_err;
    logic frm_err;
    logic brk;
    logic any_err;
  } ulsc_head_type;
  // character format for transmitter and receiver
  typedef struct packed {
    logic [1:0] word_len;
    logic stop_long;
    logic stop_half;
    logic par_en;
    logic par_even;
    logic par_force;
    logic par_forced_val;
  } ulsc_fmt_type;
endpackage : ulsc_pkg

// [hdl/ulsc_top.sv]
`timescale 1ns/100ps
`include "ulsc_defines.svh"
module ulsc_top (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  // receive path
  input wire ulsc_pkg::ulsc_rx_evt_type I_RX_EVT,
  input wire ulsc_pkg::ulsc_head_type I_RX_HEAD,
  input wire logic I_RX_AVAIL,
  input wire logic I_RX_TRIG,
  input wire logic I_RX_TIMEOUT,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_FIFO_EN,
  output logic O_RX_PUSH,
  output logic O_RX_POP,
  output logic O_RX_SER,
  // transmit path
  input wire logic I_TX_SER,
  input wire logic I_TX_HOLD_EMPTY,
  input wire logic I_TX_SHIFT_EMPTY,
  output logic O_TX,
  output logic O_THR_WRITE,
  output logic [7:0] O_THR_DATA,
  output ulsc_pkg::ulsc_fmt_type O_FMT,
  output logic [15:0] O_DIVISOR,
  output logic [7:0] O_EFR,
  // modem pins and channel interrupt
  input wire logic I_RX,
  input wire logic I_CTS_N,
  input wire logic I_DSR_N,
  input wire logic I_RI_N,
  input wire logic I_CD_N,
  output logic O_DTR_N,
  output logic O_RTS_N,
  output logic O_INT,
  output logic O_INT_OE_N,
  output logic O_PWR_DOWN
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] lcr_r, mcr_r, ier_r, efr_r;
  logic [15:0] div_r;
  logic [31:0] prdata_r;
  logic slverr_r, thr_wr_r, thr_prev_r, thre_r, thre_int_r, brk_seen_r;
  logic ovr_r, par_r, frm_r, brk_r;
  logic [7:0] thr_data_r;
  logic [3:0] cur_prev_r, delta_r;
  ulsc_pkg::ulsc_src_type snap_r, src;
  logic dlab, loop, access, rd_acc, wr_acc, hit;
  logic thr_wr, isr_rd, lsr_rd, msr_rd, thr_set, line_pend;
  logic [3:0] code, cur, delta_set;
  logic [7:0] isr_val, lsr_val, msr_val;
  logic [31:0] rdata;

  assign dlab = lcr_r[`ULSC_LCR_DLAB];
  assign loop = mcr_r[`ULSC_MCR_LOOP];
  // ----------------------------------------
  // apb handshake, zero wait states
  // ----------------------------------------
  assign access = I_PSEL & I_PENABLE;
  assign rd_acc = access & ~I_PWRITE;
  assign wr_acc = access & I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access & slverr_r;
  assign O_PRDATA = prdata_r;
  // register access strobes that carry side effects
  assign thr_wr = wr_acc & (I_PADDR == `ULSC_OFF_DATA) & ~dlab;
  assign isr_rd = rd_acc & (I_PADDR == `ULSC_OFF_ISR) & ~dlab;
  assign lsr_rd = rd_acc & (I_PADDR == `ULSC_OFF_LSR);
  assign msr_rd = rd_acc & (I_PADDR == `ULSC_OFF_MSR);
  assign O_RX_POP = rd_acc & (I_PADDR == `ULSC_OFF_DATA) & ~dlab;

  // read mux; divisor and feature register overlay the low offsets
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (I_PADDR)
      `ULSC_OFF_DATA: rdata[7:0] = dlab ? div_r[7:0] : I_RX_DATA;
      `ULSC_OFF_IER: rdata[7:0] = dlab ? div_r[15:8] : ier_r;
      `ULSC_OFF_ISR: rdata[7:0] = dlab ? efr_r : isr_val;
      `ULSC_OFF_LCR: rdata[7:0] = lcr_r;
      `ULSC_OFF_MCR: rdata[7:0] = mcr_r;
      `ULSC_OFF_LSR: rdata[7:0] = lsr_val;
      `ULSC_OFF_MSR: rdata[7:0] = msr_val;
      default: hit = 1'b0;
    endcase
  end

  // read data and source snapshot are taken in the setup cycle, so
  // the clear at the access edge hits exactly what the host saw
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
      snap_r <= ulsc_pkg::SRC_NONE;
    end else if (I_PSEL & ~I_PENABLE) begin
      prdata_r <= I_PWRITE ? 32'h0000_0000 : rdata;
      slverr_r <= ~hit;
      snap_r <= src;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      lcr_r <= `ULSC_LCR_RST;
      mcr_r <= `ULSC_MCR_RST;
      ier_r <= `ULSC_IER_RST;
      div_r <= `ULSC_DIV_RST;
      efr_r <= `ULSC_EFR_RST;
    end else if (wr_acc) begin
      case (I_PADDR)
        `ULSC_OFF_DATA: if (dlab) div_r[7:0] <= I_PWDATA[7:0];
        `ULSC_OFF_IER: begin
          if (dlab) div_r[15:8] <= I_PWDATA[7:0];
          else ier_r <= I_PWDATA[7:0] & `ULSC_IER_MASK;
        end
        `ULSC_OFF_ISR: if (dlab) efr_r <= I_PWDATA[7:0];
        `ULSC_OFF_LCR: lcr_r <= I_PWDATA[7:0];
        `ULSC_OFF_MCR: mcr_r <= I_PWDATA[7:0] & `ULSC_MCR_MASK;
        default: ;
      endcase
    end
  end

  // holding register load handed to the transmitter one cycle later
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      thr_wr_r <= 1'b0;
      thr_data_r <= 8'h00;
    end else begin
      thr_wr_r <= thr_wr;
      if (thr_wr) thr_data_r <= I_PWDATA[7:0];
    end
  end
  assign O_THR_WRITE = thr_wr_r;
  assign O_THR_DATA = thr_data_r;
  assign O_DIVISOR = div_r;
  assign O_EFR = efr_r;

  // ----------------------------------------
  // character format
  // ----------------------------------------
  // one assignment keeps the struct single-driven; fields in declaration order
  assign O_FMT = {lcr_r[1:0],
                  lcr_r[`ULSC_LCR_STOP],
                  lcr_r[`ULSC_LCR_STOP] & (lcr_r[1:0] == 2'b00),
                  lcr_r[`ULSC_LCR_PEN],
                  lcr_r[`ULSC_LCR_EVEN],
                  lcr_r[`ULSC_LCR_PEN] & lcr_r[`ULSC_LCR_FORCE],
                  ~lcr_r[`ULSC_LCR_EVEN]};

  // ----------------------------------------
  // serial pins and loop-back
  // ----------------------------------------
  // break wins over everything; in loop-back the line idles high
  assign O_TX = lcr_r[`ULSC_LCR_BRK] ? 1'b0 : (loop ? 1'b1 : I_TX_SER);
  assign O_RX_SER = loop ? (I_TX_SER & ~lcr_r[`ULSC_LCR_BRK]) : I_RX;
  // modem outputs go inactive in loop-back so the far end sees nothing
  assign O_DTR_N = loop | ~mcr_r[`ULSC_MCR_DTR];
  assign O_RTS_N = loop | ~mcr_r[`ULSC_MCR_RTS];
  assign O_PWR_DOWN = mcr_r[`ULSC_MCR_PDN] & ier_r[`ULSC_IER_PDN];
  assign O_INT = (src != ulsc_pkg::SRC_NONE);
  assign O_INT_OE_N = ~mcr_r[`ULSC_MCR_OUT];

  // ----------------------------------------
  // modem status: {cd, ri, dsr, cts}
  // ----------------------------------------
  assign cur = loop ? {mcr_r[`ULSC_MCR_OUT], mcr_r[`ULSC_MCR_RI],
                       mcr_r[`ULSC_MCR_DTR], mcr_r[`ULSC_MCR_RTS]}
                    : ~{I_CD_N, I_RI_N, I_DSR_N, I_CTS_N};
  // ring counts only its trailing edge
  assign delta_set = {cur[3] ^ cur_prev_r[3], cur_prev_r[2] & ~cur[2],
                      cur[1:0] ^ cur_prev_r[1:0]};
  assign msr_val = {cur, delta_r};

  // a change in the clearing cycle survives the clear
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      cur_prev_r <= 4'h0;
      delta_r <= 4'h0;
    end else begin
      cur_prev_r <= cur;
      if (msr_rd | (isr_rd & (snap_r == ulsc_pkg::SRC_MDM)))
        delta_r <= delta_set;
      else
        delta_r <= delta_r | delta_set;
    end
  end

  // ----------------------------------------
  // receive status
  // ----------------------------------------
  // a second break char is held back until a normal char ends the break
  assign O_RX_PUSH = I_RX_EVT.done & ~I_RX_EVT.fifo_full
                     & ~(I_RX_EVT.brk & brk_seen_r);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) brk_seen_r <= 1'b0;
    else if (O_RX_PUSH) brk_seen_r <= I_RX_EVT.brk;
  end

  // error flags clear on a status read; a new error in that cycle stays
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      ovr_r <= 1'b0;
      par_r <= 1'b0;
      frm_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      if (I_RX_EVT.done & I_RX_EVT.fifo_full) ovr_r <= 1'b1;
      else if (lsr_rd | (isr_rd & (snap_r == ulsc_pkg::SRC_LINE))) ovr_r <= 1'b0;
      if (O_RX_PUSH & I_RX_EVT.par_err) par_r <= 1'b1;
      else if (lsr_rd | (isr_rd & (snap_r == ulsc_pkg::SRC_LINE))) par_r <= 1'b0;
      if (O_RX_PUSH & I_RX_EVT.frm_err) frm_r <= 1'b1;
      else if (lsr_rd | (isr_rd & (snap_r == ulsc_pkg::SRC_LINE))) frm_r <= 1'b0;
      if (O_RX_PUSH & I_RX_EVT.brk) brk_r <= 1'b1;
      else if (lsr_rd | (isr_rd & (snap_r == ulsc_pkg::SRC_LINE))) brk_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // transmit holding empty
  // ----------------------------------------
  // only the rising edge of the empty level sets, so a stale level
  // cannot undo the clear of a host load
  assign thr_set = I_TX_HOLD_EMPTY & ~thr_prev_r;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      thr_prev_r <= 1'b1;
      thre_r <= 1'b1;
      thre_int_r <= 1'b0;
    end else begin
      thr_prev_r <= I_TX_HOLD_EMPTY;
      if (thr_set) thre_r <= 1'b1;
      else if (thr_wr) thre_r <= 1'b0;
      if (thr_set | (wr_acc & (I_PADDR == `ULSC_OFF_IER) & ~dlab
                     & I_PWDATA[`ULSC_IER_THR] & ~ier_r[`ULSC_IER_THR] & thre_r))
        thre_int_r <= 1'b1;
      else if (thr_wr | (isr_rd & (snap_r == ulsc_pkg::SRC_THR)))
        thre_int_r <= 1'b0;
    end
  end

  // fifo mode takes error flags from the head entry
  assign lsr_val = {I_FIFO_EN & I_RX_HEAD.any_err,
                    thre_r & I_TX_SHIFT_EMPTY,
                    thre_r,
                    I_FIFO_EN ? I_RX_HEAD.brk : brk_r,
                    I_FIFO_EN ? I_RX_HEAD.frm_err : frm_r,
                    I_FIFO_EN ? I_RX_HEAD.par_err : par_r,
                    ovr_r,
                    I_RX_AVAIL};

  // ----------------------------------------
  // interrupt priority
  // ----------------------------------------
  assign line_pend = ier_r[`ULSC_IER_LINE] & (|lsr_val[4:1]);

  always_comb begin
    src = ulsc_pkg::SRC_NONE;
    code = `ULSC_CODE_NONE;
    if (line_pend) begin
      src = ulsc_pkg::SRC_LINE;
      code = `ULSC_CODE_LINE;
    end else if (ier_r[`ULSC_IER_RXD] & (I_FIFO_EN ? I_RX_TRIG : I_RX_AVAIL)) begin
      src = ulsc_pkg::SRC_RXD;
      code = `ULSC_CODE_RXD;
    end else if (ier_r[`ULSC_IER_RXD] & I_FIFO_EN & I_RX_TIMEOUT) begin
      src = ulsc_pkg::SRC_TMO;
      code = `ULSC_CODE_TMO;
    end else if (ier_r[`ULSC_IER_THR] & thre_int_r) begin
      src = ulsc_pkg::SRC_THR;
      code = `ULSC_CODE_THR;
    end else if (ier_r[`ULSC_IER_MDM] & (|delta_r)) begin
      src = ulsc_pkg::SRC_MDM;
      code = `ULSC_CODE_MDM;
    end
  end
  assign isr_val = {{2{I_FIFO_EN}}, 2'b00, code};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);

  line_first_a: assert property (line_pend |-> isr_val[3:0] == 4'h6)
    else $error("line status not reported first");
  thr_clear_a: assert property (isr_rd && snap_r == ulsc_pkg::SRC_THR && !thr_set
    |=> !thre_int_r) else $error("isr read left thr interrupt set");
  idle_code_a: assert property (ier_r[3:0] == 4'h0 |-> isr_val[3:0] == 4'h1)
    else $error("code without enabled source");
  fifo_bits_a: assert property (isr_val[7:4] == {I_FIFO_EN, I_FIFO_EN, 2'b00})
    else $error("isr upper bits wrong");
  stop_half_a: assert property (O_FMT.stop_half |-> lcr_r[2] && O_FMT.word_len == 2'b00)
    else $error("half stop bit with wrong length");
  break_tx_a: assert property (lcr_r[6] |-> !O_TX)
    else $error("break not driven");
  dtr_drive_a: assert property (!loop |-> O_DTR_N == !mcr_r[0] && O_RTS_N == !mcr_r[1])
    else $error("modem outputs disagree with control");
  int_drive_a: assert property (wr_acc && I_PADDR == 8'h10 && !I_PWDATA[3] |=> O_INT_OE_N)
    else $error("interrupt driver not released");
  pwr_down_a: assert property (O_PWR_DOWN |-> mcr_r[7] && ier_r[5] && mcr_r[6:5] == 2'b00)
    else $error("power-down without both enables");
  overrun_set_a: assert property (I_RX_EVT.done && I_RX_EVT.fifo_full
    |-> !O_RX_PUSH ##1 lsr_val[1]) else $error("overrun not flagged");
  single_brk_a: assert property (I_RX_EVT.done && I_RX_EVT.brk && brk_seen_r
    |-> !O_RX_PUSH) else $error("second break char pushed");
  thre_clr_a: assert property (thr_wr && !thr_set |=> !lsr_val[5])
    else $error("holding empty not cleared by load");
  loop_msr_a: assert property (loop |-> msr_val[7:4] == {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]})
    else $error("loop-back status mismatch");
  temt_a: assert property (lsr_val[6] |-> lsr_val[5] && I_TX_SHIFT_EMPTY)
    else $error("transmitter empty too early");
  // clears and forced levels that the bench reaches only indirectly
  force_par_a: assert property (O_FMT.par_force |-> O_FMT.par_en)
    else $error("parity forced while parity off");
  line_clear_a: assert property (isr_rd && snap_r == ulsc_pkg::SRC_LINE && !I_RX_EVT.done
    |=> !ovr_r && !par_r && !frm_r && !brk_r) else $error("isr read left line flags set");
  mdm_clear_a: assert property (isr_rd && snap_r == ulsc_pkg::SRC_MDM && cur == cur_prev_r
    |=> delta_r == 4'h0) else $error("isr read left modem deltas set");
  int_pin_a: assert property (O_INT == !isr_val[0])
    else $error("interrupt pin disagrees with pending bit");
  rx_ready_a: assert property (lsr_val[0] == I_RX_AVAIL)
    else $error("data ready bit wrong");
  loop_tx_a: assert property (loop && !lcr_r[6] |-> O_TX)
    else $error("serial pin not idle in loop-back");
  pwr_hold_a: assert property (!mcr_r[7] |-> !O_PWR_DOWN)
    else $error("power-down without control bit");
endmodule : ulsc_top

// [testbench/ulsc_tx_model.sv]
`timescale 1ns/100ps
module ulsc_tx_model #(
  parameter int HOLD_CYC = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // handoff from the control block
  input wire logic i_thr_write,
  // transmit stage status
  output logic o_hold_empty,
  output logic o_shift_empty,
  output logic o_tx_ser
);
  logic [7:0] cnt_r;
  // holding stage empties halfway through the count, the shifter at its end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= 8'h00;
    end else if (i_thr_write) begin
      cnt_r <= 8'(2 * HOLD_CYC);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // line toggles while shifting so a stuck output is not mistaken for idle
  assign o_hold_empty = (cnt_r <= 8'(HOLD_CYC));
  assign o_shift_empty = (cnt_r == 8'h00);
  assign o_tx_ser = o_shift_empty | cnt_r[0];
endmodule : ulsc_tx_model

// [testbench/uart_line_status_control_tb.sv]
`timescale 1ns/100ps
`include "ulsc_defines.svh"
module uart_line_status_control_tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  ulsc_pkg::ulsc_rx_evt_type rx_evt = '0;
  ulsc_pkg::ulsc_head_type rx_head = '0;
  logic rx_avail = 1'b0;
  logic rx_tmo = 1'b0;
  logic fifo_en = 1'b0;
  logic cts_n = 1'b1;
  logic rx_line = 1'b1;
  logic pready, pslverr, rx_push, rx_ser, tx, thr_write, int_o, int_oe_n, pwr_down, dtr_n, rts_n;
  logic hold_empty, shift_empty, tx_ser, err, rx_pop;
  int pop_cnt = 0;
  logic [31:0] prdata, rd;
  logic [7:0] thr_data, efr, v, fexp;
  logic [15:0] divisor;
  ulsc_pkg::ulsc_fmt_type fmt;
  logic [7:0] lcr_tab [5] = '{8'h00, 8'h05, 8'h1a, 8'h3f, 8'h2c};
  logic [7:0] thr_last = 8'h00;
  int n_fail = 0;
  int checks_done = 0;
  int thr_cnt = 0;
  int c0;

  always #12.5 clk = ~clk;

  ulsc_top u_dut (
    .I_CLK_SYS(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PRDATA(prdata), .I_RX_EVT(rx_evt), .I_RX_HEAD(rx_head), .I_RX_AVAIL(rx_avail),
    .I_RX_TRIG(1'b0), .I_RX_TIMEOUT(rx_tmo), .I_RX_DATA(8'h3c), .I_FIFO_EN(fifo_en),
    .O_RX_PUSH(rx_push), .O_RX_POP(rx_pop), .O_RX_SER(rx_ser), .I_TX_SER(tx_ser),
    .I_TX_HOLD_EMPTY(hold_empty), .I_TX_SHIFT_EMPTY(shift_empty), .O_TX(tx),
    .O_THR_WRITE(thr_write), .O_THR_DATA(thr_data), .O_FMT(fmt), .O_DIVISOR(divisor),
    .O_EFR(efr), .I_RX(rx_line), .I_CTS_N(cts_n), .I_DSR_N(1'b1), .I_RI_N(1'b1),
    .I_CD_N(1'b1), .O_DTR_N(dtr_n), .O_RTS_N(rts_n), .O_INT(int_o),
    .O_INT_OE_N(int_oe_n), .O_PWR_DOWN(pwr_down)
  );

  ulsc_tx_model u_model (
    .i_clk(clk), .i_srst(srst), .i_thr_write(thr_write), .o_hold_empty(hold_empty),
    .o_shift_empty(shift_empty), .o_tx_ser(tx_ser)
  );

  // count handoffs so a write that should not reach the transmitter is seen
  always @(posedge clk) begin
    if (thr_write === 1'b1) begin
      thr_cnt <= thr_cnt + 1;
      thr_last <= thr_data;
    end
    if (rx_pop === 1'b1) begin
      pop_cnt <= pop_cnt + 1;
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // one apb transfer; an idle cycle follows so psel is never driven twice at one edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk(name, rd & {24'h0, m}, {24'h0, e});
  endtask : rdc

  // push is combinational, so it is looked at within the cycle that carries done
  task automatic rx_ev(input ulsc_pkg::ulsc_rx_evt_type ev, input logic exp_push);
    rx_evt <= ev;
    #1;
    chk("rx push", 32'(rx_push), 32'(exp_push));
    @(posedge clk);
    rx_evt <= '0;
    @(posedge clk);
  endtask : rx_ev

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdc("isr", `ULSC_OFF_ISR, 8'hff, 8'h01);
    rdc("lcr", `ULSC_OFF_LCR, 8'hff, 8'h00);
    rdc("mcr", `ULSC_OFF_MCR, 8'hff, 8'h00);
    rdc("lsr", `ULSC_OFF_LSR, 8'hff, 8'h60);
    chk("dtr_n", 32'(dtr_n), 32'h1);
    chk("int_oe_n", 32'(int_oe_n), 32'h1);
    // format fields, shortest length with both stop settings, longest with the long stop, and no, even and both forced parity modes
    foreach (lcr_tab[k]) begin
      v = lcr_tab[k];
      fexp = {v[1:0], v[2], v[2] & ~(|v[1:0]), v[3], v[4], v[3] & v[5], ~v[4]};
      wr(`ULSC_OFF_LCR, v);
      rdc("lcr", `ULSC_OFF_LCR, 8'hff, v);
      chk("fmt", 32'(fmt), 32'(fexp));
    end
    wr(`ULSC_OFF_LCR, 8'h43);
    chk("tx break", 32'(tx), 32'h0);
    wr(`ULSC_OFF_LCR, 8'h03);
    chk("tx idle", 32'(tx), 32'h1);
    wr(`ULSC_OFF_LCR, 8'h83);
    wr(`ULSC_OFF_DATA, 8'h34);
    wr(`ULSC_OFF_IER, 8'h12);
    wr(`ULSC_OFF_ISR, 8'h5a);
    chk("divisor", 32'(divisor), 32'h1234);
    chk("efr", 32'(efr), 32'h5a);
    chk("thr count", thr_cnt, 0);
    wr(`ULSC_OFF_LCR, 8'h03);
    // modem control, loop-back and power-down
    wr(`ULSC_OFF_MCR, 8'hff);
    rdc("mcr", `ULSC_OFF_MCR, 8'hff, 8'h9f);
    rdc("msr loop", `ULSC_OFF_MSR, 8'hf0, 8'hf0);
    chk("tx loop", 32'(tx), 32'h1);
    chk("pwr mcr only", 32'(pwr_down), 32'h0);
    chk("int_oe_n", 32'(int_oe_n), 32'h0);
    wr(`ULSC_OFF_IER, 8'h20);
    chk("pwr both", 32'(pwr_down), 32'h1);
    wr(`ULSC_OFF_IER, 8'h00);
    wr(`ULSC_OFF_MCR, 8'h07);
    rdc("msr normal", `ULSC_OFF_MSR, 8'hf0, 8'h00);
    chk("dtr_n", 32'(dtr_n), 32'h0);
    chk("rts_n", 32'(rts_n), 32'h0);
    rx_line <= 1'b0;
    @(posedge clk);
    chk("rx ser", 32'(rx_ser), 32'h0);
    rx_line <= 1'b1;
    // all four levels pending at once, then serviced one by one
    wr(`ULSC_OFF_MCR, 8'h0f);
    rx_avail <= 1'b1;
    cts_n <= 1'b0;
    rx_ev(5'h14, 1'b1);
    wr(`ULSC_OFF_IER, 8'h0f);
    chk("int pin", 32'(int_o), 32'h1);
    rdc("isr line", `ULSC_OFF_ISR, 8'hff, 8'h06);
    rdc("isr rxd", `ULSC_OFF_ISR, 8'hff, 8'h04);
    rdc("isr rxd held", `ULSC_OFF_ISR, 8'hff, 8'h04);
    rx_avail <= 1'b0;
    @(posedge clk);
    rdc("isr thr", `ULSC_OFF_ISR, 8'hff, 8'h02);
    rdc("isr modem", `ULSC_OFF_ISR, 8'hff, 8'h00);
    rdc("isr none", `ULSC_OFF_ISR, 8'hff, 8'h01);
    chk("int idle", 32'(int_o), 32'h0);
    fifo_en <= 1'b1;
    rx_avail <= 1'b1;
    rx_tmo <= 1'b1;
    @(posedge clk);
    rdc("isr tmo", `ULSC_OFF_ISR, 8'hff, 8'hcc);
    rx_tmo <= 1'b0;
    rx_head <= 4'hd;
    @(posedge clk);
    rdc("lsr head", `ULSC_OFF_LSR, 8'hff, 8'hed);
    rx_head <= 4'h0;
    rx_avail <= 1'b0;
    @(posedge clk);
    rdc("isr fifo", `ULSC_OFF_ISR, 8'hff, 8'hc1);
    // one break character per break, overrun keeps the fifo intact
    rx_ev(5'h11, 1'b1);
    rx_ev(5'h11, 1'b0);
    rx_ev(5'h10, 1'b1);
    rx_ev(5'h18, 1'b0);
    rdc("lsr overrun", `ULSC_OFF_LSR, 8'h02, 8'h02);
    rdc("lsr cleared", `ULSC_OFF_LSR, 8'h03, 8'h00);
    fifo_en <= 1'b0;
    rx_ev(5'h11, 1'b1);
    rdc("lsr break", `ULSC_OFF_LSR, 8'h1e, 8'h10);
    // holding and shifter empty flags follow the transmitter
    c0 = thr_cnt;
    wr(`ULSC_OFF_DATA, 8'ha5);
    rdc("lsr busy", `ULSC_OFF_LSR, 8'h60, 8'h00);
    chk("thr count", thr_cnt - c0, 1);
    chk("thr data", 32'(thr_last), 32'ha5);
    repeat (5) @(posedge clk);
    rdc("lsr hold", `ULSC_OFF_LSR, 8'h60, 8'h20);
    repeat (8) @(posedge clk);
    rdc("lsr idle", `ULSC_OFF_LSR, 8'h60, 8'h60);
    c0 = pop_cnt;
    rdc("rx data", `ULSC_OFF_DATA, 8'hff, 8'h3c);
    chk("pop count", pop_cnt - c0, 1);
    xfer(1'b1, 8'h1c, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    complete_run();
  end
endmodule : uart_line_status_control_tb
